//--- core/tism_pkg.sv
// constants, layout and helpers of the timed interrupt start and mask block
package tism_pkg;

   // ==========================================================
   // source layout
   localparam int SRC_W = 24;
   localparam int NUM_TIMERS = 4;
   localparam int FAULT_BIT = 0;
   localparam int TIMER_BIT0 = 15;
   localparam int IV_W = 16;
   localparam int ID_W = 5;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // ==========================================================
   // register byte offsets
   localparam logic [ADDR_W-1:0] ADDR_SELECTOR = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_START = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_DISABLE = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_ENABLE = 8'h0c;
   localparam logic [ADDR_W-1:0] ADDR_MASK = 8'h10;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h14;
   localparam logic [ADDR_W-1:0] ADDR_TIMERS = 8'h18;
   localparam logic [ADDR_W-1:0] ADDR_CLAIM = 8'h1c;
   localparam logic [ADDR_W-1:0] ADDR_DONE = 8'h20;
   localparam logic [ADDR_W-1:0] ADDR_INSERV = 8'h24;

   // ==========================================================
   // field positions and reset values
   localparam int START_EN_BIT = 16;
   localparam int TIMERS_STAT_BIT = 8;
   localparam int CLAIM_VALID_BIT = 5;
   localparam logic [SRC_W-1:0] MASK_RESET = 24'hffffff;
   localparam logic [SRC_W-1:0] STATUS_RESET = 24'h000000;
   // selector values are arbitrary; timer k answers to base plus k
   localparam logic [DATA_W-1:0] TIMER0_SELECTOR_ID = 32'h00000000;

   // ==========================================================
   // timing
   localparam int CLOCK_PERIOD_NS = 4;
   localparam int TIME_BASE_MS = 1;
   localparam int NS_PER_MS = 1000000;
   localparam int TICK_CYCLES = (TIME_BASE_MS * NS_PER_MS + CLOCK_PERIOD_NS - 1)
                                / CLOCK_PERIOD_NS;
   localparam int PRESC_W = 18;

   // lowest set index, which is also the highest priority
   function automatic logic [ID_W:0] first_set(input logic [SRC_W-1:0] v);
      logic [ID_W:0] r;
      r = '0;
      for (int i = SRC_W - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = {1'b1, ID_W'(i)};
         end
      end
      return r;
   endfunction : first_set

endpackage : tism_pkg

//--- core/tism_timer.sv
// one periodic millisecond interval timer
`timescale 1ns/1ps
module tism_timer #(
   parameter int TICK_CYCLES = tism_pkg::TICK_CYCLES
) (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // start command
   input wire logic load,
   input wire logic [tism_pkg::IV_W-1:0] interval_ms,
   // state
   output logic running_q,
   output logic fire_q
);
   import tism_pkg::*;

   logic [IV_W-1:0] sp_q;
   logic [IV_W-1:0] ms_q;
   logic [PRESC_W-1:0] sub_q;
   logic restart;
   logic ms_end;
   logic period_end;

   assign restart = load && interval_ms != 16'h0000 && (!running_q || interval_ms != sp_q);
   assign ms_end = sub_q == PRESC_W'(TICK_CYCLES - 1);
   assign period_end = running_q && ms_end && ms_q == sp_q - 16'h0001;

   // ==========================================================
   // run state and set point
   always_ff @(posedge clock) begin
      if (!resetn) begin
         running_q <= 1'b0;
         sp_q <= '0;
      end else if (load && interval_ms == 16'h0000) begin
         running_q <= 1'b0;
      end else if (restart) begin
         running_q <= 1'b1;
         sp_q <= interval_ms;
      end
   end

   // ==========================================================
   // elapsed time, restarted from zero by a new set point
   always_ff @(posedge clock) begin
      if (!resetn) begin
         ms_q <= '0;
         sub_q <= '0;
      end else if (restart || !running_q) begin
         ms_q <= '0;
         sub_q <= '0;
      end else if (ms_end) begin
         sub_q <= '0;
         ms_q <= period_end ? 16'h0000 : ms_q + 16'h0001;
      end else begin
         sub_q <= sub_q + PRESC_W'(1);
      end
   end

   // ==========================================================
   // request after the full interval
   always_ff @(posedge clock) begin
      if (!resetn) begin
         fire_q <= 1'b0;
      end else begin
         fire_q <= period_end && !restart && !(load && interval_ms == 16'h0000);
      end
   end

   // ==========================================================
   // checks
   logic [31:0] el_q;
   always_ff @(posedge clock) begin
      if (!resetn || restart || period_end || !running_q) begin
         el_q <= '0;
      end else begin
         el_q <= el_q + 32'd1;
      end
   end

   chk_zero_stops: assert property (@(posedge clock) disable iff (!resetn)
      load && interval_ms == 16'h0000 |=> !running_q)
      else $error("zero set point did not stop timer");

   chk_idle_start: assert property (@(posedge clock) disable iff (!resetn)
      load && interval_ms != 16'h0000 && !running_q
      |=> running_q && ms_q == 16'h0000 && sp_q == $past(interval_ms))
      else $error("idle timer did not start");

   chk_retime_now: assert property (@(posedge clock) disable iff (!resetn)
      load && running_q && interval_ms != 16'h0000 && interval_ms != sp_q
      |=> sub_q == '0 && ms_q == 16'h0000 && sp_q == $past(interval_ms))
      else $error("new set point not applied at once");

   chk_full_range: assert property (@(posedge clock) disable iff (!resetn)
      load && interval_ms == 16'hffff |=> running_q && sp_q == 16'hffff)
      else $error("largest set point refused");

   chk_fire_period: assert property (@(posedge clock) disable iff (!resetn)
      $rose(fire_q) || (fire_q && $past(fire_q) == 1'b0)
      |-> $past(el_q) == 32'(sp_q) * 32'(TICK_CYCLES) - 32'd1)
      else $error("timed request at wrong time");

   chk_reset_idle: assert property (@(posedge clock)
      !resetn |=> !running_q && !fire_q)
      else $error("timer not idle after reset");

endmodule : tism_timer

//--- core/tism_top.sv
// interrupt enable mask, pending and service logic with four interval timers
// Operation
// - command status equals the enable input
// - interval is any 16-bit millisecond count
// - zero interval stops timer, command status keeps enable
// - idle timer starts on nonzero interval
// - new interval restarts running timer from zero
// - request after full interval elapsed
// - disable clears enables of selected sources
// - enable sets enables of selected sources
// - fixed bit map of the 24 sources
// - each source weighs two to its bit
// - enable and disable share bit positions
// - service in fixed priority, bit 0 first
// - higher request preempts lower routine
// - all enabled pending dispatched highest to lowest
`timescale 1ns/1ps
module tism_top #(
   parameter int TICK_CYCLES = tism_pkg::TICK_CYCLES
) (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // register port
   input wire logic [tism_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [tism_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [tism_pkg::DATA_W-1:0] reg_rdata,
   // interrupt source pins
   input wire logic [tism_pkg::SRC_W-1:0] source_req,
   // status outputs
   output logic irq,
   output logic preempt_req,
   output logic command_status_out,
   output logic [tism_pkg::NUM_TIMERS-1:0] timer_running
);
   import tism_pkg::*;

   // ==========================================================
   // state
   logic [DATA_W-1:0] selector_q;
   logic [SRC_W-1:0] mask_q;
   logic [SRC_W-1:0] status_q;
   logic [SRC_W-1:0] status_d;
   logic [SRC_W-1:0] inserv_q;
   logic [SRC_W-1:0] meta_q;
   logic [SRC_W-1:0] sync_q;
   logic [SRC_W-1:0] prev_q;
   logic [DATA_W-1:0] rdata_q;
   logic irq_q;
   logic preempt_q;
   logic cmd_status_q;

   // ==========================================================
   // decode
   logic wr_selector;
   logic wr_start;
   logic wr_disable;
   logic wr_enable;
   logic wr_done;
   logic rd_status;
   logic rd_claim;

   always_comb begin
      wr_selector = 1'b0;
      wr_start = 1'b0;
      wr_disable = 1'b0;
      wr_enable = 1'b0;
      wr_done = 1'b0;
      rd_status = 1'b0;
      rd_claim = 1'b0;
      if (reg_write && reg_addr == ADDR_SELECTOR) begin
         wr_selector = 1'b1;
      end else if (reg_write && reg_addr == ADDR_START) begin
         wr_start = 1'b1;
      end else if (reg_write && reg_addr == ADDR_DISABLE) begin
         wr_disable = 1'b1;
      end else if (reg_write && reg_addr == ADDR_ENABLE) begin
         wr_enable = 1'b1;
      end else if (reg_write && reg_addr == ADDR_DONE) begin
         wr_done = 1'b1;
      end else if (reg_read && reg_addr == ADDR_STATUS) begin
         rd_status = 1'b1;
      end else if (reg_read && reg_addr == ADDR_CLAIM) begin
         rd_claim = 1'b1;
      end
   end

   // ==========================================================
   // start command
   logic start_en;
   logic [IV_W-1:0] start_iv;
   logic [NUM_TIMERS-1:0] load;
   logic [NUM_TIMERS-1:0] fire;

   assign start_en = reg_wdata[START_EN_BIT];
   assign start_iv = reg_wdata[IV_W-1:0];

   always_comb begin
      for (int k = 0; k < NUM_TIMERS; k++) begin
         load[k] = wr_start && start_en && selector_q == TIMER0_SELECTOR_ID + 32'(k);
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         selector_q <= '0;
      end else if (wr_selector) begin
         selector_q <= reg_wdata;
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         cmd_status_q <= 1'b0;
      end else if (wr_start) begin
         cmd_status_q <= start_en;
      end
   end

   for (genvar g = 0; g < NUM_TIMERS; g++) begin : g_timer
      tism_timer #(
         .TICK_CYCLES(TICK_CYCLES)
      ) u_timer (
         .clock(clock),
         .resetn(resetn),
         .load(load[g]),
         .interval_ms(start_iv),
         .running_q(timer_running[g]),
         .fire_q(fire[g])
      );
   end

   // ==========================================================
   // source pins: two-stage sync, then rising edge
   always_ff @(posedge clock) begin
      if (!resetn) begin
         meta_q <= '0;
         sync_q <= '0;
         prev_q <= '0;
      end else begin
         meta_q <= source_req;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   // timer bits come from the timers, not from the pins
   logic [SRC_W-1:0] timer_bits;
   logic [SRC_W-1:0] pin_bits;
   logic [SRC_W-1:0] set_vec;

   assign timer_bits = SRC_W'(fire) << TIMER_BIT0;
   assign pin_bits = ~(SRC_W'({NUM_TIMERS{1'b1}}) << TIMER_BIT0);
   assign set_vec = (sync_q & ~prev_q & pin_bits) | timer_bits;

   // ==========================================================
   // enable mask
   always_ff @(posedge clock) begin
      if (!resetn) begin
         mask_q <= MASK_RESET;
      end else if (wr_disable) begin
         mask_q <= mask_q & ~reg_wdata[SRC_W-1:0];
      end else if (wr_enable) begin
         mask_q <= mask_q | reg_wdata[SRC_W-1:0];
      end
   end

   // ==========================================================
   // priority and service
   logic [ID_W:0] pend_pick;
   logic [ID_W:0] serv_pick;
   logic claimable;

   assign pend_pick = first_set(status_q & mask_q);
   assign serv_pick = first_set(inserv_q);
   assign claimable = pend_pick[ID_W] &&
                      (!serv_pick[ID_W] || pend_pick[ID_W-1:0] < serv_pick[ID_W-1:0]);

   // a new event wins over a clear in the same cycle
   always_comb begin
      status_d = status_q;
      if (rd_status) begin
         status_d = '0;
      end else if (rd_claim && claimable) begin
         status_d[pend_pick[ID_W-1:0]] = 1'b0;
      end
      status_d = status_d | set_vec;
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         status_q <= STATUS_RESET;
      end else begin
         status_q <= status_d;
      end
   end

   // the most recently claimed routine is the highest one in service
   always_ff @(posedge clock) begin
      if (!resetn) begin
         inserv_q <= '0;
      end else if (rd_claim && claimable) begin
         inserv_q[pend_pick[ID_W-1:0]] <= 1'b1;
      end else if (wr_done && serv_pick[ID_W]) begin
         inserv_q[serv_pick[ID_W-1:0]] <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         irq_q <= 1'b0;
         preempt_q <= 1'b0;
      end else begin
         irq_q <= |(status_d & mask_q);
         preempt_q <= claimable;
      end
   end

   // ==========================================================
   // read data, valid the cycle after the strobe
   always_ff @(posedge clock) begin
      if (!resetn) begin
         rdata_q <= '0;
      end else if (!reg_read) begin
         rdata_q <= '0;
      end else if (reg_addr == ADDR_SELECTOR) begin
         rdata_q <= selector_q;
      end else if (reg_addr == ADDR_MASK) begin
         rdata_q <= DATA_W'(mask_q);
      end else if (reg_addr == ADDR_STATUS) begin
         rdata_q <= DATA_W'(status_q);
      end else if (reg_addr == ADDR_TIMERS) begin
         rdata_q <= (DATA_W'(cmd_status_q) << TIMERS_STAT_BIT) | DATA_W'(timer_running);
      end else if (reg_addr == ADDR_CLAIM) begin
         rdata_q <= DATA_W'({claimable, pend_pick[ID_W-1:0]});
      end else if (reg_addr == ADDR_INSERV) begin
         rdata_q <= DATA_W'(inserv_q);
      end else begin
         rdata_q <= '0;
      end
   end

   assign reg_rdata = rdata_q;
   assign irq = irq_q;
   assign preempt_req = preempt_q;
   assign command_status_out = cmd_status_q;

   // ==========================================================
   // checks
   chk_status_follows: assert property (@(posedge clock) disable iff (!resetn)
      wr_start |=> command_status_out == $past(reg_wdata[START_EN_BIT]))
      else $error("command status differs from enable");

   chk_disabled_start: assert property (@(posedge clock) disable iff (!resetn)
      wr_start && !start_en |-> load == '0)
      else $error("start acted while not enabled");

   chk_disable_clears: assert property (@(posedge clock) disable iff (!resetn)
      wr_disable |=> mask_q == ($past(mask_q) & ~$past(reg_wdata[SRC_W-1:0])))
      else $error("disable did not clear selected bits only");

   chk_enable_sets: assert property (@(posedge clock) disable iff (!resetn)
      wr_enable |=> mask_q == ($past(mask_q) | $past(reg_wdata[SRC_W-1:0])))
      else $error("enable did not set selected bits only");

   chk_mask_holds: assert property (@(posedge clock) disable iff (!resetn)
      !wr_disable && !wr_enable |=> $stable(mask_q))
      else $error("mask changed without a command");

   chk_claim_priority: assert property (@(posedge clock) disable iff (!resetn)
      rd_claim && claimable
      |=> reg_rdata[ID_W-1:0] == $past(pend_pick[ID_W-1:0]) && reg_rdata[CLAIM_VALID_BIT])
      else $error("claim did not return highest pending");

   chk_set_wins: assert property (@(posedge clock) disable iff (!resetn)
      rd_status && set_vec != '0 |=> (status_q & $past(set_vec)) == $past(set_vec))
      else $error("event lost against clear");

   chk_timer_bit: assert property (@(posedge clock) disable iff (!resetn)
      fire[0] |=> status_q[TIMER_BIT0])
      else $error("timer 0 did not set its bit");

   chk_irq_level: assert property (@(posedge clock) disable iff (!resetn)
      (status_q & mask_q) != '0 && !rd_status && !rd_claim |=> irq)
      else $error("interrupt low with unmasked status");

   chk_claim_marks: assert property (@(posedge clock) disable iff (!resetn)
      rd_claim && claimable && set_vec == '0
      |=> inserv_q[$past(pend_pick[ID_W-1:0])] && !status_q[$past(pend_pick[ID_W-1:0])])
      else $error("claim did not move source into service");

   chk_none_higher: assert property (@(posedge clock) disable iff (!resetn)
      rd_claim && claimable
      |-> (status_q & mask_q & ((SRC_W'(1) << pend_pick[ID_W-1:0]) - SRC_W'(1))) == '0)
      else $error("claimed source has a higher one pending");

   chk_masked_wait: assert property (@(posedge clock) disable iff (!resetn)
      rd_claim && claimable |-> mask_q[pend_pick[ID_W-1:0]])
      else $error("disabled source was serviced");

   chk_lower_waits: assert property (@(posedge clock) disable iff (!resetn)
      rd_claim && !claimable |=> $stable(inserv_q))
      else $error("lower request entered service");

   chk_done_pops: assert property (@(posedge clock) disable iff (!resetn)
      wr_done && serv_pick[ID_W] |=> !inserv_q[$past(serv_pick[ID_W-1:0])])
      else $error("finished routine still in service");

   chk_no_preempt: assert property (@(posedge clock) disable iff (!resetn)
      serv_pick[ID_W] && pend_pick[ID_W-1:0] > serv_pick[ID_W-1:0] |=> !preempt_req)
      else $error("lower request raised preemption");

   chk_status_clear: assert property (@(posedge clock) disable iff (!resetn)
      rd_status && set_vec == '0 |=> status_q == '0)
      else $error("status read did not clear");

   chk_event_lands: assert property (@(posedge clock) disable iff (!resetn)
      set_vec != '0 |=> (status_q & $past(set_vec)) == $past(set_vec))
      else $error("source event not recorded");

   chk_cmd_holds: assert property (@(posedge clock) disable iff (!resetn)
      !wr_start |=> $stable(command_status_out))
      else $error("command status changed without a start");

   chk_top_reset: assert property (@(posedge clock)
      !resetn |=> !irq && !preempt_req && timer_running == '0 && mask_q == MASK_RESET)
      else $error("block not idle after reset");

endmodule : tism_top

//--- sim/tism_cpu.sv
// processor side model: issues register commands to the interrupt block
`timescale 1ns/1ps
module tism_cpu (
   // clock
   input wire logic clock,
   // register port
   output logic [tism_pkg::ADDR_W-1:0] reg_addr,
   output logic [tism_pkg::DATA_W-1:0] reg_wdata,
   output logic reg_write,
   output logic reg_read
);
   import tism_pkg::*;

   initial begin
      reg_addr = '0;
      reg_wdata = '0;
      reg_write = 1'b0;
      reg_read = 1'b0;
   end

   // ==========================================================
   // bus cycles; each starts just after an edge and returns at the edge that takes it
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      reg_read <= 1'b0;
      @(posedge clock);
   endtask : wr

   task automatic rd(input logic [ADDR_W-1:0] a);
      reg_addr <= a;
      reg_read <= 1'b1;
      reg_write <= 1'b0;
      @(posedge clock);
   endtask : rd

   // released bus shows the inverse of its last value; a second idle in a row restores the old copy
   task automatic idle(input int n);
      reg_write <= 1'b0;
      reg_read <= 1'b0;
      reg_addr <= ~reg_addr;
      reg_wdata <= ~reg_wdata;
      repeat (n) @(posedge clock);
   endtask : idle

   // ==========================================================
   // commands
   function automatic logic [SRC_W-1:0] weight(input int b);
      return SRC_W'(1) << b;
   endfunction : weight

   task automatic start_timer(input int k, input logic [IV_W-1:0] sp, input logic en);
      wr(ADDR_SELECTOR, TIMER0_SELECTOR_ID + 32'(k));
      wr(ADDR_START, {15'h0000, en, sp});
   endtask : start_timer

   task automatic mask_cmd(input logic dis, input logic [SRC_W-1:0] w);
      wr(dis ? ADDR_DISABLE : ADDR_ENABLE, {8'h00, w});
   endtask : mask_cmd

endmodule : tism_cpu

//--- sim/tb.sv
// self-checking testbench of the timed interrupt start and mask block
`timescale 1ns/1ps
module tb;
   import tism_pkg::*;
   localparam int TICKS = 10;
   logic clock, resetn, reg_write, reg_read, irq, preempt_req, command_status_out;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata, reg_rdata, w;
   logic [SRC_W-1:0] source_req, mask_m, ev_m;
   logic [NUM_TIMERS-1:0] timer_running;
   logic rd_seen = 1'b0;
   logic [DATA_W-1:0] exp_q[$];
   string nm_q[$];
   int bad_count, comparisons;
   integer seed;

   tism_top #(.TICK_CYCLES(TICKS)) DUT (.clock(clock), .resetn(resetn),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .source_req(source_req), .irq(irq),
      .preempt_req(preempt_req), .command_status_out(command_status_out),
      .timer_running(timer_running));

   tism_cpu cpu (.clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read));

   // ==========================================================
   // compare and report
   task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_word

   task automatic chk_pin(input string nm, input logic [3:0] e, input logic [3:0] g);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_pin

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : tally_and_finish

   // read data stand only in the cycle after the strobe
   always @(posedge clock) begin
      if (rd_seen) begin
         if (exp_q.size() == 0) begin
            chk_word("unexpected read", 32'h0, 32'hffffffff);
         end else begin
            chk_word(nm_q.pop_front(), exp_q.pop_front(), reg_rdata);
         end
      end
      rd_seen <= reg_read;
   end

   task automatic rdx(input logic [ADDR_W-1:0] a, input logic [31:0] e, input string nm);
      cpu.rd(a);
      exp_q.push_back(e);
      nm_q.push_back(nm);
   endtask : rdx

   function automatic logic [31:0] claim(input int i);
      return (32'h1 << CLAIM_VALID_BIT) | 32'(i);
   endfunction : claim

   // counts edges from the taking edge of a start until irq is seen
   task automatic wait_irq(input int n_exp, input string nm);
      int n;
      n = 0;
      cpu.idle(0);
      while (n < 700) begin
         @(posedge clock);
         n++;
         if (irq === 1'b1) break;
      end
      if (n >= 700) begin
         bad_count++;
         tally_and_finish();
      end
      chk_word(nm, 32'(n_exp), 32'(n));
   endtask : wait_irq

   task automatic pulse(input logic [SRC_W-1:0] v);
      source_req <= v;
      cpu.idle(2);
      source_req <= '0;
      cpu.idle(5);
   endtask : pulse

   // ==========================================================
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   initial begin
      #200000;
      bad_count++;
      tally_and_finish();
   end

   initial begin
      seed = 32'hbfa26a94;
      bad_count = 0;
      comparisons = 0;
      resetn = 1'b0;
      source_req = '0;
      repeat (8) @(posedge clock);
      resetn <= 1'b1;
      repeat (2) @(posedge clock);
      // reset state and unmapped places
      chk_pin("timer_running", 4'h0, timer_running);
      chk_pin("pins", 4'h0, {1'b0, irq, preempt_req, command_status_out});
      cpu.wr(8'h3c, 32'h00000000);
      rdx(ADDR_MASK, 32'(MASK_RESET), "mask reset");
      rdx(ADDR_TIMERS, 32'h0, "timers reset");
      rdx(ADDR_STATUS, 32'(STATUS_RESET), "status reset");
      rdx(ADDR_SELECTOR, 32'h0, "selector reset");
      rdx(8'h3c, 32'h0, "unmapped");
      cpu.idle(2);
      $display("test reset done");
      // mask commands, fixed then random
      cpu.mask_cmd(1'b1, cpu.weight(2) + cpu.weight(4));
      rdx(ADDR_MASK, 32'h00ffffeb, "mask after disable");
      cpu.mask_cmd(1'b0, 24'd4);
      rdx(ADDR_MASK, 32'h00ffffef, "mask after enable");
      mask_m = 24'hffffef;
      for (int i = 0; i < 16; i++) begin
         w = $random(seed);
         cpu.mask_cmd(w[31], w[23:0]);
         mask_m = w[31] ? (mask_m & ~w[23:0]) : (mask_m | w[23:0]);
         rdx(ADDR_MASK, 32'(mask_m), "mask random");
      end
      cpu.idle(2);
      $display("test mask done");
      // each timer in turn: delay, status bit, stop
      for (int k = 0; k < NUM_TIMERS; k++) begin
         cpu.mask_cmd(1'b1, 24'hffffff);
         cpu.mask_cmd(1'b0, cpu.weight(TIMER_BIT0 + k));
         cpu.start_timer(k, 16'd2, 1'b1);
         wait_irq(2 * TICKS + 2, "timer delay");
         chk_pin("timer_running", 4'(1 << k), timer_running);
         rdx(ADDR_STATUS, 32'h1 << (TIMER_BIT0 + k), "timer status");
         cpu.start_timer(k, 16'd0, 1'b1);
         cpu.idle(25);
         chk_pin("timer_running", 4'h0, timer_running);
         chk_pin("irq cmd", 4'h1, {2'b00, irq, command_status_out});
      end
      $display("test timers done");
      // refused start, restart with a new interval, full-range interval
      cpu.mask_cmd(1'b0, 24'hffffff);
      cpu.start_timer(0, 16'd5, 1'b1);
      cpu.idle(30);
      cpu.start_timer(0, 16'd0, 1'b0);
      cpu.idle(1);
      chk_pin("cmd status", 4'h0, {3'b000, command_status_out});
      chk_pin("timer_running", 4'h1, timer_running);
      cpu.start_timer(0, 16'd3, 1'b1);
      wait_irq(3 * TICKS + 2, "restart delay");
      cpu.start_timer(0, 16'd0, 1'b1);
      cpu.start_timer(1, 16'hffff, 1'b1);
      rdx(ADDR_TIMERS, (32'h1 << TIMERS_STAT_BIT) | 32'h2, "timers max");
      rdx(ADDR_STATUS, 32'h1 << TIMER_BIT0, "status restart");
      cpu.start_timer(1, 16'd0, 1'b1);
      cpu.idle(3);
      chk_pin("timer_running", 4'h0, timer_running);
      $display("test restart done");
      // priority, preemption and dispatch of all pending
      pulse(24'h100014);
      chk_pin("irq preempt", 4'h3, {2'b00, irq, preempt_req});
      rdx(ADDR_CLAIM, claim(2), "claim first");
      rdx(ADDR_CLAIM, 32'h4, "claim lower");
      rdx(ADDR_INSERV, 32'h4, "inserv");
      cpu.idle(2);
      chk_pin("preempt", 4'h0, {3'b000, preempt_req});
      pulse(24'h000002);
      chk_pin("preempt", 4'h1, {3'b000, preempt_req});
      rdx(ADDR_CLAIM, claim(1), "claim preempt");
      cpu.wr(ADDR_DONE, 32'h0);
      rdx(ADDR_INSERV, 32'h4, "inserv resumed");
      cpu.wr(ADDR_DONE, 32'h0);
      rdx(ADDR_CLAIM, claim(4), "claim next");
      cpu.wr(ADDR_DONE, 32'h0);
      rdx(ADDR_CLAIM, claim(20), "claim last");
      cpu.wr(ADDR_DONE, 32'h0);
      rdx(ADDR_CLAIM, 32'h0, "claim empty");
      cpu.idle(3);
      chk_pin("irq", 4'h0, {3'b000, irq});
      // a disabled source stays pending but is not serviced
      cpu.mask_cmd(1'b1, cpu.weight(3));
      cpu.idle(1);
      pulse(24'h000008);
      rdx(ADDR_CLAIM, 32'h0, "claim masked");
      cpu.idle(2);
      chk_pin("irq", 4'h0, {3'b000, irq});
      cpu.mask_cmd(1'b0, cpu.weight(3));
      rdx(ADDR_CLAIM, claim(3), "claim unmasked");
      cpu.wr(ADDR_DONE, 32'h0);
      cpu.idle(3);
      // random pin events, pairs of inverse words reach every pin
      for (int i = 0; i < 6; i++) begin
         w = i[0] ? ~w : $random(seed);
         ev_m = w[23:0] & ~(24'hf << TIMER_BIT0);
         pulse(w[23:0]);
         chk_pin("irq random", {2'b00, |ev_m, |ev_m}, {2'b00, irq, preempt_req});
         rdx(ADDR_STATUS, 32'(ev_m), "status random");
      end
      cpu.idle(2);
      $display("test service done");
      tally_and_finish();
   end

endmodule : tb
